/* verilog/imsspi_pkg.sv */
// package of constants for the inertial sensor serial slave port
package imsspi_pkg;
   // frame layout
   localparam int FRAME_BITS = 16;
   localparam int ADDR_BITS = 7;
   localparam int FRAME_MSB = 15;
   localparam int RW_BIT = 15;
   localparam int ADDR_LSB = 8;
   // clock rate
   localparam int CLK_MHZ = 100;
   // mode threshold on the sample period setting
   localparam logic [7:0] NORMAL_MAX_PERIOD = 8'h09;
   localparam logic [7:0] LOWPWR_MIN_PERIOD = 8'h0A;
   // timing figures in microseconds and derived cycle counts
   localparam int STALL_NORMAL_US = 9;
   localparam int STALL_LOWPWR_US = 75;
   localparam int SYNC_HIGH_MIN_US = 5;
   localparam int SYNC_PERIOD_MIN_US = 833;
   localparam int SYNC_TO_READY_US = 600;
   localparam int STALL_NORMAL_CYC = STALL_NORMAL_US * CLK_MHZ;
   localparam int STALL_LOWPWR_CYC = STALL_LOWPWR_US * CLK_MHZ;
   localparam int SYNC_HIGH_MIN_CYC = SYNC_HIGH_MIN_US * CLK_MHZ;
   localparam int SYNC_PERIOD_MIN_CYC = SYNC_PERIOD_MIN_US * CLK_MHZ;
   localparam int SYNC_TO_READY_CYC = SYNC_TO_READY_US * CLK_MHZ;
   // width of the data ready pulse in cycles
   localparam int READY_PULSE_CYC = 4;
   // buffer shape
   localparam int FIFO_WIDTH = 16;
   localparam int FIFO_DEPTH = 16;
   // reset values
   localparam logic [15:0] SAMPLE_RESET = 16'h0000;
   typedef enum logic [1:0] {
      IMSSPI_IDLE = 2'b00,
      IMSSPI_SHIFT = 2'b01,
      IMSSPI_STALL = 2'b11
   } imsspi_state_e;
endpackage : imsspi_pkg

/* verilog/imsspi_fifo.sv */
// parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module imsspi_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // --------------------------------------------------------------
   // handshakes
   // --------------------------------------------------------------
   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH)); // full once the count reaches the depth
   assign out_valid_o = (cnt_q != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_q];

   // storage array, written only, no reset needed
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // pointers and fill count
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_q <= cnt_q - (AW+1)'(1);
         end
      end
   end
endmodule : imsspi_fifo

/* verilog/imsspi_core.sv */
// serial slave port, sync clock input and data ready of the inertial sensor
// Overview of operation
// - incoming bits are taken on rising serial clock edges while select is low.
// - the outgoing bit changes on falling serial clock edges.
// - data ready follows each sync pulse after 600 us.
// - the fourth digital pin is general input/output or sync clock input.
// - sample period up to 0x09 is normal mode, 0x0A and above is low power.
// - mode 3, clock idles high, 16-bit frames, most significant bit first.
// - a read frame holds flag zero and an address; data returns next frame.
// - each buffer pop loads the output word; with sync off, data ready pulses high on the same edge.
`timescale 1ns/1ps
module imsspi_core #(
   parameter int STALL_NORMAL = imsspi_pkg::STALL_NORMAL_CYC,
   parameter int STALL_LOWPWR = imsspi_pkg::STALL_LOWPWR_CYC,
   parameter int SYNC_TO_READY = imsspi_pkg::SYNC_TO_READY_CYC,
   parameter int SYNC_PERIOD_MIN = imsspi_pkg::SYNC_PERIOD_MIN_CYC
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   output logic dout_o,
   input wire logic [7:0] sample_period_setting_i,
   input wire logic sync_clock_enable_i,
   input wire logic gpio4_or_sync_clock_in_i,
   output logic gpio4_or_sync_clock_in_o,
   output logic gpio4_or_sync_clock_in_oe_o,
   input wire logic gpio4_out_i,
   input wire logic gpio4_dir_out_i,
   output logic gpio4_in_o,
   input wire logic [imsspi_pkg::FIFO_WIDTH-1:0] sample_data_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   output logic gpio1_data_ready_out_o,
   output logic low_power_mode_o,
   output logic sync_error_o,
   output logic [imsspi_pkg::ADDR_BITS-1:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic wr_strobe_o,
   output logic [imsspi_pkg::ADDR_BITS-1:0] rd_addr_o
);
   import imsspi_pkg::*;

   // --------------------------------------------------------------
   // input synchronisers
   // --------------------------------------------------------------
   logic [1:0] sclk_s_q;
   logic [1:0] cs_s_q;
   logic [1:0] din_s_q;
   logic [1:0] sync_s_q;
   logic sclk_prev_q;
   logic sync_prev_q;

   // two flops on every pin; edges are found from the second stage only
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sclk_s_q <= 2'h3;
         cs_s_q <= 2'h3;
         din_s_q <= 2'h0;
         sync_s_q <= 2'h0;
         sclk_prev_q <= 1'b1;
         sync_prev_q <= 1'b0;
      end else begin
         sclk_s_q <= {sclk_s_q[0], sclk_i};
         cs_s_q <= {cs_s_q[0], cs_n_i};
         din_s_q <= {din_s_q[0], din_i};
         sync_s_q <= {sync_s_q[0], gpio4_or_sync_clock_in_i};
         sclk_prev_q <= sclk_s_q[1];
         sync_prev_q <= sync_s_q[1];
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_act;
   assign cs_act = ~cs_s_q[1];
   assign sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
   assign sclk_fall = ~sclk_s_q[1] & sclk_prev_q;

   // --------------------------------------------------------------
   // mode select
   // --------------------------------------------------------------
   // low power once the sample period reaches its threshold
   assign low_power_mode_o = (sample_period_setting_i >= LOWPWR_MIN_PERIOD);

   // --------------------------------------------------------------
   // sample buffer and output word
   // --------------------------------------------------------------
   logic [FIFO_WIDTH-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;
   logic [FIFO_WIDTH-1:0] out_word_q;

   imsspi_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .in_data_i(sample_data_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop)
   );

   // --------------------------------------------------------------
   // frame engine
   // --------------------------------------------------------------
   imsspi_state_e state_q;
   logic [FRAME_BITS-1:0] rx_q;
   logic [FRAME_BITS-1:0] tx_q;
   logic [4:0] bit_cnt_q;
   logic read_pend_q;
   logic frame_done;
   logic [FRAME_BITS-1:0] rx_next;

   assign rx_next = {rx_q[FRAME_MSB-1:0], din_s_q[1]};
   assign frame_done = sclk_rise && cs_act && (bit_cnt_q == 5'(FRAME_BITS - 1));
   // the buffer drains only while select is released, so data loads between frames
   assign fifo_pop = fifo_valid && !cs_act;

   // receive shift and bit count; select released mid-frame drops the frame
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_q <= IMSSPI_IDLE;
         rx_q <= '0;
         bit_cnt_q <= '0;
      end else begin
         case (state_q)
            IMSSPI_IDLE: begin
               bit_cnt_q <= '0;
               if (cs_act) begin
                  state_q <= IMSSPI_SHIFT;
               end
            end
            IMSSPI_SHIFT: begin
               if (!cs_act) begin
                  state_q <= IMSSPI_IDLE;
               end else if (sclk_rise) begin
                  rx_q <= rx_next;
                  bit_cnt_q <= bit_cnt_q + 5'd1;
                  if (frame_done) begin
                     state_q <= IMSSPI_STALL;
                  end
               end
            end
            IMSSPI_STALL: begin
               if (!cs_act) begin
                  state_q <= IMSSPI_IDLE;
               end
            end
            default: begin
               state_q <= IMSSPI_IDLE;
            end
         endcase
      end
   end

   // decode a completed frame: read flag zero latches an address, one writes a byte
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         read_pend_q <= 1'b0;
         rd_addr_o <= '0;
         wr_addr_o <= '0;
         wr_data_o <= '0;
         wr_strobe_o <= 1'b0;
      end else begin
         wr_strobe_o <= 1'b0;
         if (frame_done) begin
            if (!rx_next[RW_BIT]) begin
               read_pend_q <= 1'b1;
               rd_addr_o <= rx_next[ADDR_LSB +: ADDR_BITS];
            end else begin
               read_pend_q <= 1'b0;
               wr_addr_o <= rx_next[ADDR_LSB +: ADDR_BITS];
               wr_data_o <= rx_next[7:0];
               wr_strobe_o <= 1'b1;
            end
         end
      end
   end

   // newest sample word, loaded on each buffer pop
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         out_word_q <= SAMPLE_RESET;
      end else if (fifo_pop) begin
         out_word_q <= fifo_data;
      end
   end

   // transmit: load at frame start, shift on falling edges, msb first
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tx_q <= '0;
      end else if (state_q == IMSSPI_IDLE && cs_act) begin
         tx_q <= read_pend_q ? out_word_q : '0;
      end else if (state_q == IMSSPI_SHIFT && sclk_fall && bit_cnt_q != 5'd0) begin
         tx_q <= {tx_q[FRAME_MSB-1:0], 1'b0};
      end
   end
   assign dout_o = tx_q[FRAME_MSB];

   // --------------------------------------------------------------
   // sync input and data ready
   // --------------------------------------------------------------
   logic [23:0] sync_cnt_q;
   logic sync_busy_q;
   logic [23:0] sync_gap_q;
   logic [2:0] rdy_cnt_q;
   logic sync_rise;
   logic new_sample;

   assign sync_rise = sync_clock_enable_i && sync_s_q[1] && !sync_prev_q;
   // internal sampling loads on each buffer pop when the sync clock is off
   assign new_sample = sync_clock_enable_i ? (sync_busy_q && sync_cnt_q == 24'd1)
                                           : fifo_pop;

   // delay from a sync edge to data ready; short periods flag an error
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sync_cnt_q <= '0;
         sync_busy_q <= 1'b0;
         sync_gap_q <= '0;
         sync_error_o <= 1'b0;
      end else begin
         if (sync_gap_q != '0) begin
            sync_gap_q <= sync_gap_q - 24'd1;
         end
         if (sync_rise) begin
            sync_cnt_q <= 24'(SYNC_TO_READY);
            sync_busy_q <= 1'b1;
            sync_gap_q <= 24'(SYNC_PERIOD_MIN);
            sync_error_o <= (sync_gap_q != '0);
         end else if (sync_busy_q) begin
            sync_cnt_q <= sync_cnt_q - 24'd1;
            if (sync_cnt_q == 24'd1) begin
               sync_busy_q <= 1'b0;
            end
         end
      end
   end

   // stretched data ready pulse on the first digital pin
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdy_cnt_q <= '0;
      end else if (new_sample) begin
         rdy_cnt_q <= 3'(READY_PULSE_CYC);
      end else if (rdy_cnt_q != '0) begin
         rdy_cnt_q <= rdy_cnt_q - 3'd1;
      end
   end
   assign gpio1_data_ready_out_o = (rdy_cnt_q != '0);

   // --------------------------------------------------------------
   // fourth pin: general input/output or sync clock input
   // --------------------------------------------------------------
   // never drive the pin while it serves as the sync clock input
   assign gpio4_or_sync_clock_in_oe_o = gpio4_dir_out_i && !sync_clock_enable_i;
   assign gpio4_or_sync_clock_in_o = gpio4_out_i;
   assign gpio4_in_o = sync_s_q[1];
endmodule : imsspi_core

/* verif/imsspi_core_monitor.sv */
// concurrent checks on the ports of the serial slave port core
`timescale 1ns/1ps
module imsspi_core_monitor #(
   parameter int SYNC_TO_READY = 50
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic dout_o,
   input wire logic [7:0] sample_period_setting_i,
   input wire logic sync_clock_enable_i,
   input wire logic gpio4_or_sync_clock_in_i,
   input wire logic gpio4_or_sync_clock_in_o,
   input wire logic gpio4_or_sync_clock_in_oe_o,
   input wire logic gpio4_out_i,
   input wire logic gpio4_dir_out_i,
   input wire logic gpio4_in_o,
   input wire logic gpio1_data_ready_out_o,
   input wire logic low_power_mode_o,
   input wire logic wr_strobe_o
);
   // allow a few cycles of pin synchronisation on top of the sync delay
   localparam int RDY_LO = SYNC_TO_READY;
   localparam int RDY_HI = SYNC_TO_READY + 8;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   property p_mode;
      low_power_mode_o == (sample_period_setting_i >= 8'h0A);
   endproperty
   a_mode: assert property (p_mode) else $error("mode flag wrong");
   // output may only move after a falling serial clock edge or at frame start, when the word is loaded
   property p_hold;
      (sclk_i && !cs_n_i)[*6] |-> $stable(dout_o);
   endproperty
   a_hold: assert property (p_hold) else $error("dout moved");
   property p_pulse;
      $rose(gpio1_data_ready_out_o) |-> gpio1_data_ready_out_o[*4];
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready pulse short");
   property p_sync;
      sync_clock_enable_i && $rose(gpio4_or_sync_clock_in_i)
         |-> ##[RDY_LO:RDY_HI] $rose(gpio1_data_ready_out_o);
   endproperty
   a_sync: assert property (p_sync) else $error("no ready after sync");
   property p_oe;
      ($stable(gpio4_dir_out_i) && $stable(sync_clock_enable_i))[*3]
         |-> gpio4_or_sync_clock_in_oe_o == (gpio4_dir_out_i && !sync_clock_enable_i);
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable wrong");
   property p_out;
      (gpio4_or_sync_clock_in_oe_o && $stable(gpio4_out_i))[*3]
         |-> gpio4_or_sync_clock_in_o == gpio4_out_i;
   endproperty
   a_out: assert property (p_out) else $error("pin value wrong");
   property p_in;
      $stable(gpio4_or_sync_clock_in_i)[*4] |-> gpio4_in_o == gpio4_or_sync_clock_in_i;
   endproperty
   a_in: assert property (p_in) else $error("pin input wrong");
   property p_strobe;
      wr_strobe_o |=> !wr_strobe_o[*8];
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe too long");
   // a decoded frame ends inside a selection, after a rising clock edge
   property p_cap;
      wr_strobe_o |-> !cs_n_i && sclk_i;
   endproperty
   a_cap: assert property (p_cap) else $error("strobe outside frame");
   c_wr: cover property (wr_strobe_o);
   c_rdy: cover property ($rose(gpio1_data_ready_out_o));
   c_lp: cover property (low_power_mode_o);
endmodule : imsspi_core_monitor
bind imsspi_core imsspi_core_monitor #(.SYNC_TO_READY(SYNC_TO_READY)) u_mon (
   .core_clk_i(core_clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
   .dout_o(dout_o), .sample_period_setting_i(sample_period_setting_i),
   .sync_clock_enable_i(sync_clock_enable_i),
   .gpio4_or_sync_clock_in_i(gpio4_or_sync_clock_in_i),
   .gpio4_or_sync_clock_in_o(gpio4_or_sync_clock_in_o),
   .gpio4_or_sync_clock_in_oe_o(gpio4_or_sync_clock_in_oe_o),
   .gpio4_out_i(gpio4_out_i), .gpio4_dir_out_i(gpio4_dir_out_i), .gpio4_in_o(gpio4_in_o),
   .gpio1_data_ready_out_o(gpio1_data_ready_out_o),
   .low_power_mode_o(low_power_mode_o), .wr_strobe_o(wr_strobe_o));

/* verif/imsspi_master.sv */
// serial bus master model driving the slave port in mode 3
`timescale 1ns/1ps
module imsspi_master (
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   input wire logic dout_i,
   input wire logic low_power_i
);
   initial begin
      sclk_o = 1'b1; // clock idles high
      cs_n_o = 1'b1;
      din_o = 1'b0;
   end
   // one frame msb first, then the idle stall that the mode needs
   task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
      cs_n_o = 1'b0; // held low for the whole frame
      #62.5;
      for (int i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         din_o = tx[i]; // launched on the falling edge
         #62.5;
         sclk_o = 1'b1;
         rx[i] = dout_i; // taken on the rising edge
         #62.5;
      end
      cs_n_o = 1'b1;
      din_o = ~din_o; // a released line must not keep its last level
      #(low_power_i ? 75000 : 9000);
   endtask : frame
   // holds the selection without clocks, which the device treats as an aborted frame
   task automatic select(input logic sel);
      cs_n_o = ~sel;
   endtask : select
endmodule : imsspi_master

/* verif/tb_top.sv */
// self-checking bench for the serial slave port core
`timescale 1ns/1ps
module tb_top;
   import imsspi_pkg::*;
   // shortened sync delay keeps the run short; checks below use the same figure
   localparam int T_SYNC = 50;
   logic core_clk_i, srst_i, sclk, cs_n, din, dout, sync_en, pin_o, pin_oe, pin_drv;
   logic g_out, g_dir, g_in, svalid, sready, rdy, rdy_q, lp, serr, wr_stb;
   logic [7:0] setting, wr_data;
   logic [15:0] sdata, rx;
   logic [6:0] wr_addr, rd_addr;
   wire pin = pin_oe ? pin_o : pin_drv;
   int bad_count = 0, cmp_count = 0, rdy_cnt = 0, stb_cnt = 0, cyc = 0;
   imsspi_core #(.SYNC_TO_READY(T_SYNC), .SYNC_PERIOD_MIN(100)) dut (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
      .dout_o(dout), .sample_period_setting_i(setting), .sync_clock_enable_i(sync_en),
      .gpio4_or_sync_clock_in_i(pin), .gpio4_or_sync_clock_in_o(pin_o),
      .gpio4_or_sync_clock_in_oe_o(pin_oe), .gpio4_out_i(g_out), .gpio4_dir_out_i(g_dir),
      .gpio4_in_o(g_in), .sample_data_i(sdata), .sample_valid_i(svalid),
      .sample_ready_o(sready), .gpio1_data_ready_out_o(rdy), .low_power_mode_o(lp),
      .sync_error_o(serr), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
      .wr_strobe_o(wr_stb), .rd_addr_o(rd_addr));
   imsspi_master u_mst (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
      .low_power_i(lp));
   // -------------------------------------
   // clock, event counters and hang guard
   // -------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      rdy_q <= rdy;
      if (wr_stb === 1'b1) stb_cnt++;
      if (rdy === 1'b1 && rdy_q === 1'b0) rdy_cnt++;
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         final_report();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   // -------------------------------------
   // scenarios
   // -------------------------------------
   task automatic t_mode();
      logic [7:0] tab [4] = '{8'h00, 8'h09, 8'h0A, 8'hFF};
      foreach (tab[i]) begin
         @(negedge core_clk_i) setting = tab[i];
         @(negedge core_clk_i) chk("low_power", 16'(tab[i] >= LOWPWR_MIN_PERIOD), 16'(lp));
      end
      $display("mode test done");
   endtask : t_mode
   task automatic t_gpio();
      @(negedge core_clk_i) {g_dir, g_out} = 2'b11;
      repeat (4) @(negedge core_clk_i);
      chk("pin_drive", 16'h0003, {14'h0, pin_oe, pin_o});
      g_dir = 1'b0;
      pin_drv = 1'b0; // opposite of the level just driven, so a stuck input shows
      repeat (5) @(negedge core_clk_i);
      chk("pin_input", 16'h0000, {14'h0, pin_oe, g_in});
      $display("gpio test done");
   endtask : t_gpio
   // low power stall after a write frame that sets a byte
   task automatic t_write();
      int s0 = stb_cnt;
      @(negedge core_clk_i) setting = 8'h0A;
      u_mst.frame(16'hA11F, rx);
      chk("wr_addr", 16'h0021, 16'(wr_addr));
      chk("wr_data", 16'h001F, 16'(wr_data));
      chk("strobes", 16'(s0 + 1), 16'(stb_cnt));
      @(negedge core_clk_i) setting = 8'h01;
      $display("write test done");
   endtask : t_write
   // fill the buffer with the far side stalled, drain it, then read the newest word
   task automatic t_buffer();
      int n = 0;
      int r0 = rdy_cnt;
      u_mst.select(1'b1);
      for (int i = 0; i < 24; i++) begin
         @(negedge core_clk_i);
         sdata = 16'h1000 + 16'(n);
         svalid = 1'b1;
         if (sready === 1'b1) n++;
      end
      @(negedge core_clk_i) svalid = 1'b0;
      chk("fill", 16'(FIFO_DEPTH), 16'(n));
      chk("no_pulse", 16'(r0), 16'(rdy_cnt));
      u_mst.select(1'b0);
      repeat (100) @(negedge core_clk_i);
      chk("drained", 16'h0001, 16'(sready));
      chk("pulsed", 16'h0001, 16'(rdy_cnt > r0));
      u_mst.frame(16'h0A00, rx);
      chk("rd_addr", 16'h000A, 16'(rd_addr));
      u_mst.frame(16'h0000, rx);
      chk("read", 16'h100F, rx);
      $display("buffer test done");
   endtask : t_buffer
   // a legal sync pulse, then one sent too soon on purpose, which must be flagged
   task automatic t_sync();
      int k = 0;
      @(negedge core_clk_i) {sync_en, pin_drv, g_dir} = 3'b101;
      repeat (4) @(negedge core_clk_i);
      chk("pin_released", 16'h0000, 16'(pin_oe));
      pin_drv = 1'b1; // first pulse, legal spacing
      while (rdy !== 1'b1 && k < 100) begin
         @(negedge core_clk_i) k++;
      end
      chk("sync_delay", 16'h0001, 16'(k >= T_SYNC && k <= T_SYNC + 8));
      chk("sync_error", 16'h0000, 16'(serr));
      pin_drv = 1'b0;
      repeat (8) @(negedge core_clk_i);
      pin_drv = 1'b1; // inside the minimum period, so the error flag must rise
      k = 0;
      while (rdy !== 1'b1 && k < 100) begin
         @(negedge core_clk_i) k++;
      end
      chk("sync_delay2", 16'h0001, 16'(k >= T_SYNC && k <= T_SYNC + 8));
      chk("sync_error_early", 16'h0001, 16'(serr));
      repeat (SYNC_HIGH_MIN_CYC) @(negedge core_clk_i);
      {sync_en, pin_drv, g_dir} = 3'b000;
      $display("sync test done");
   endtask : t_sync
   initial begin
      {srst_i, sync_en, pin_drv, g_out, g_dir, svalid} = 6'b100000;
      setting = 8'h01;
      sdata = 16'h0000;
      repeat (12) @(negedge core_clk_i);
      srst_i = 1'b0;
      t_mode();
      t_gpio();
      t_write();
      t_buffer();
      t_sync();
      final_report();
   end
endmodule : tb_top
